// ### hdl/asu_regs.vh
// Register offsets, field positions, reset values and timing counts of the serial block.
//
// Overview of operation
// - Line idles at mark; start bit space, 8 or 9 data bits, stop bits mark.
// - Data travels least significant bit first; both directions share format and rate.
// - An 8-bit or 16-bit divisor sets the bit period from the system clock.
// - No hardware parity; software carries any parity in the ninth bit.
// - Asynchronous transmit needs transmit enable 1, sync select 0, port enable 1.
// - Port enable turns the block on and drives the transmit pin.
// - Transmit-empty flag sets as soon as transmit enable is set.
// - Holding write moves to idle shifter at once, else right after stop bit.
// - Polarity bit 0 gives high idle and data; 1 inverts transmit output.
// - Transmit-empty is clear while transmit is off or the shifter is busy with a character queued; read-only.
// - Transmit-empty becomes valid in the second instruction cycle after the write.
// - Transmit-empty follows the holding state; interrupt enable only gates the request.
// - Auto-baud sets overflow if the 16-bit counter wraps before fifth rising edge.
// - Overflow sets receive flag; counting continues until the fifth rising edge.
// - During auto-baud receive-idle stays 0 until the fifth rising edge sets it.
// - Receive data read after overflow means fifth rising edge sets receive flag again.
// - Auto-baud stopped early leaves remaining falling edges seen as start bits.
// - Clocks stop in sleep; wake on receive activity only in asynchronous mode.
// - With wake enable set, reception is off and a falling edge is the wake event.
// - Wake event raises receive flag; reading receive data clears it.
// - Hardware clears wake enable on the rising edge ending the break.
`ifndef ASU_REGS_VH
`define ASU_REGS_VH

// -----------------------------------------------------------------------------
// Register addresses
// -----------------------------------------------------------------------------
`define ASU_ADDR_TX_STATUS_CONTROL 4'h0
`define ASU_ADDR_RX_STATUS_CONTROL 4'h1
`define ASU_ADDR_BAUD_CONTROL      4'h2
`define ASU_ADDR_DIVISOR_LOW       4'h3
`define ASU_ADDR_DIVISOR_HIGH      4'h4
`define ASU_ADDR_TX_HOLDING        4'h5
`define ASU_ADDR_RX_DATA           4'h6
`define ASU_ADDR_PERIPH_FLAG       4'h7
`define ASU_ADDR_PERIPH_ENABLE     4'h8

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define ASU_TXC_NINTH_DATA   0
`define ASU_TXC_SHIFT_EMPTY  1
`define ASU_TXC_BRG_HIGH     2
`define ASU_TXC_SYNC         4
`define ASU_TXC_TX_ENABLE    5
`define ASU_TXC_NINE_BIT     6
`define ASU_RXC_NINTH_DATA   0
`define ASU_RXC_OVERRUN      1
`define ASU_RXC_FRAMING      2
`define ASU_RXC_RX_ENABLE    4
`define ASU_RXC_NINE_BIT     6
`define ASU_RXC_PORT_ENABLE  7
`define ASU_BC_AUTOBAUD_EN   0
`define ASU_BC_WAKE_EN       1
`define ASU_BC_DIV16         3
`define ASU_BC_POLARITY      4
`define ASU_BC_RX_IDLE       6
`define ASU_BC_AB_OVERFLOW   7
`define ASU_PF_RX_READY      5
`define ASU_PF_TX_EMPTY      4

// -----------------------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------------------
`define ASU_RST_BYTE         8'h00
`define ASU_TCY_CLOCKS       4
`define ASU_AB_EDGES         3'h5

`endif

// ### hdl/asu_serial.v
// Asynchronous serial transceiver with auto-baud and wake-on-break.
`timescale 1ns/1ps
`include "asu_regs.vh"

module asu_serial
(
	input  wire       i_core_clk,
	input  wire       i_sys_rst,
	input  wire [3:0] i_addr,
	input  wire [7:0] i_wdata,
	input  wire       i_wr,
	input  wire       i_rd,
	output reg  [7:0] o_rdata,
	input  wire       i_receive_pin,
	output reg        o_transmit_pin,
	output wire       o_transmit_pin_oe,
	output wire       o_tx_irq_req,
	output wire       o_rx_irq_req
);

	// -------------------------------------------------------------------------
	// Control registers
	// -------------------------------------------------------------------------
	reg  [7:0]  tx_status_control_reg;
	reg  [7:0]  rx_status_control_reg;
	reg  [7:0]  baud_control_reg;
	reg  [7:0]  divisor_low;
	reg  [7:0]  baud_divisor_high;
	reg  [8:0]  tx_holding_register;
	reg         hold_full;
	reg  [8:0]  rx_data_register;
	reg         rx_ready_flag;
	reg         overrun;
	reg         framing;
	reg  [1:0]  peripheral_enable_reg;
	reg  [1:0]  tcy_cnt;
	reg  [1:0]  txe_hold;
	reg         tx_empty_flag;
	wire        port_on;
	wire        async_tx;
	wire        nine_tx;
	wire        nine_rx;
	wire        polarity;
	wire        wake_en;
	wire        ab_en;
	wire [15:0] divisor;
	wire        tcy_tick;

	assign port_on  = rx_status_control_reg[`ASU_RXC_PORT_ENABLE];
	assign async_tx = tx_status_control_reg[`ASU_TXC_TX_ENABLE] & port_on
		& ~tx_status_control_reg[`ASU_TXC_SYNC];
	assign nine_tx  = tx_status_control_reg[`ASU_TXC_NINE_BIT];
	assign nine_rx  = rx_status_control_reg[`ASU_RXC_NINE_BIT];
	assign polarity = baud_control_reg[`ASU_BC_POLARITY];
	assign wake_en  = baud_control_reg[`ASU_BC_WAKE_EN];
	assign ab_en    = baud_control_reg[`ASU_BC_AUTOBAUD_EN];
	// Eight-bit mode ignores the high divisor byte.
	assign divisor  = baud_control_reg[`ASU_BC_DIV16] ? {baud_divisor_high, divisor_low}
		: {8'h00, divisor_low};
	assign tcy_tick = (tcy_cnt == 2'h3);

	// Pin is driven whenever the port is on.
	assign o_transmit_pin_oe = port_on;

	// -------------------------------------------------------------------------
	// Receive pin synchroniser and edge detect
	// -------------------------------------------------------------------------
	reg  rx_meta;
	reg  rx_sync;
	reg  rx_prev;
	wire rx_fall;
	wire rx_rise;

	// Two flops bring the pin into the clock domain.
	always @(posedge i_core_clk)
	begin
		rx_meta <= i_receive_pin;
		rx_sync <= rx_meta;
		rx_prev <= rx_sync;
	end
	assign rx_fall = rx_prev & ~rx_sync;
	assign rx_rise = ~rx_prev & rx_sync;

	// -------------------------------------------------------------------------
	// Baud generator (16 divider ticks per bit; one divider shared by TX and RX)
	// -------------------------------------------------------------------------
	reg  [15:0] brg_cnt;
	reg  [3:0]  tx_sub;
	wire        brg_tick;
	wire        tx_bit_tick;
	wire        tx_load;

	assign brg_tick    = (brg_cnt == 16'h0000);
	assign tx_bit_tick = brg_tick & (tx_sub == 4'hf);

	// Free-running divider; one enable pulse every divisor+1 clocks.
	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			brg_cnt <= 16'h0000;
			tx_sub  <= 4'h0;
			tcy_cnt <= 2'h0;
		end
		else
		begin
			brg_cnt <= brg_tick ? divisor : brg_cnt - 16'h0001;
			// A load restarts the bit phase so the start bit lasts a full period.
			if (tx_load)
				tx_sub <= 4'h0;
			else if (brg_tick)
				tx_sub <= tx_sub + 4'h1;
			tcy_cnt <= tcy_cnt + 2'h1;
		end
	end

	// -------------------------------------------------------------------------
	// Transmitter
	// -------------------------------------------------------------------------
	reg  [10:0] tx_shift_register;
	reg  [3:0]  tx_bits;
	reg         tx_busy;
	reg         tx_stop_done;

	// Shifter loads from the holding register when idle; after a stop bit
	// the idle state lasts until the next tcy_tick, at most one instruction cycle.
	assign tx_load = async_tx & hold_full & ~tx_busy & (tcy_tick | ~tx_stop_done);

	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			tx_shift_register <= 11'h7ff;
			tx_bits           <= 4'h0;
			tx_busy           <= 1'b0;
			tx_stop_done      <= 1'b0;
			o_transmit_pin    <= 1'b1;
		end
		else
		begin
			// The post-stop wait ends at the next tcy_tick, at most one instruction cycle; then the shifter counts as empty.
			if (tcy_tick)
				tx_stop_done <= 1'b0;
			if (tx_load)
			begin
				// Stop, optional ninth bit, eight data, start; LSB shifts first.
				tx_shift_register <= {1'b1, nine_tx ? tx_holding_register[8] : 1'b1,
					tx_holding_register[7:0], 1'b0};
				tx_bits      <= nine_tx ? 4'hb : 4'ha;
				tx_busy      <= 1'b1;
				tx_stop_done <= 1'b0;
			end
			else if (tx_busy & tx_bit_tick)
			begin
				tx_shift_register <= {1'b1, tx_shift_register[10:1]};
				tx_bits <= tx_bits - 4'h1;
				if (tx_bits == 4'h1)
				begin
					tx_busy      <= 1'b0;
					tx_stop_done <= 1'b1;
				end
			end
			else if (~async_tx)
				tx_busy <= 1'b0;
			// Each bit holds for one baud period; polarity flips idle and data.
			o_transmit_pin <= (tx_busy ? tx_shift_register[0] : 1'b1) ^ polarity;
		end
	end

	// -------------------------------------------------------------------------
	// Transmit-empty flag, delayed to the second instruction cycle after a write
	// -------------------------------------------------------------------------
	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			txe_hold      <= 2'h0;
			tx_empty_flag <= 1'b0;
		end
		else
		begin
			if (i_wr & (i_addr == `ASU_ADDR_TX_HOLDING))
				txe_hold <= 2'h2;
			else if (tcy_tick & (txe_hold != 2'h0))
				txe_hold <= txe_hold - 2'h1;
			// Flag follows holding state, independent of interrupt enable.
			if (~async_tx)
				tx_empty_flag <= 1'b0;
			else if (txe_hold == 2'h0)
				tx_empty_flag <= ~hold_full;
		end
	end
	assign o_tx_irq_req = tx_empty_flag & peripheral_enable_reg[0];

	// -------------------------------------------------------------------------
	// Receiver, auto-baud and wake
	// -------------------------------------------------------------------------
	localparam RX_IDLE  = 4'b0001;
	localparam RX_SHIFT = 4'b0010;
	localparam RX_AUTO  = 4'b0100;
	localparam RX_WAKE  = 4'b1000;

	reg  [3:0]  rx_state;
	reg  [3:0]  rx_sub;
	reg  [3:0]  rx_bits;
	reg  [9:0]  rx_shift;
	reg  [2:0]  ab_edges;
	reg  [15:0] ab_cnt;
	reg         ab_ovf;
	reg         wake_clr;
	reg         ab_done;
	reg  [15:0] ab_result;
	reg         rx_set;
	reg         rx_sync_low_seen_n;
	wire        rx_read;

	assign rx_read = i_rd & (i_addr == `ASU_ADDR_RX_DATA);

	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			rx_state  <= RX_IDLE;
			rx_sub    <= 4'h0;
			rx_bits   <= 4'h0;
			rx_shift  <= 10'h000;
			ab_edges  <= 3'h0;
			ab_cnt    <= 16'h0000;
			ab_ovf    <= 1'b0;
			wake_clr  <= 1'b0;
			ab_done   <= 1'b0;
			ab_result <= 16'h0000;
			rx_set    <= 1'b0;
			rx_data_register <= 9'h000;
			overrun   <= 1'b0;
			framing   <= 1'b0;
		end
		else
		begin
			rx_set   <= 1'b0;
			wake_clr <= 1'b0;
			ab_done  <= 1'b0;
			if (i_wr & (i_addr == `ASU_ADDR_BAUD_CONTROL) & ~i_wdata[`ASU_BC_AB_OVERFLOW])
				ab_ovf <= 1'b0;
			if (i_wr & (i_addr == `ASU_ADDR_RX_STATUS_CONTROL) & ~i_wdata[`ASU_RXC_RX_ENABLE])
				overrun <= 1'b0;
			case (rx_state)
				RX_IDLE:
				begin
					if (port_on & wake_en & ~tx_status_control_reg[`ASU_TXC_SYNC])
						rx_state <= RX_WAKE;
					else if (port_on & ab_en)
					begin
						rx_state <= RX_AUTO;
						ab_edges <= 3'h0;
						ab_cnt   <= 16'h0000;
					end
					else if (port_on & rx_status_control_reg[`ASU_RXC_RX_ENABLE] & rx_fall)
					begin
						rx_state <= RX_SHIFT;
						rx_sub   <= 4'h0;
						rx_bits  <= nine_rx ? 4'hb : 4'ha;
					end
				end
				RX_SHIFT:
				begin
					if (brg_tick)
					begin
						rx_sub <= rx_sub + 4'h1;
						// Sample at the middle of each sixteen-tick bit.
						if (rx_sub == 4'h7)
						begin
							rx_shift <= {rx_sync, rx_shift[9:1]};
							rx_bits  <= rx_bits - 4'h1;
							if (rx_bits == 4'h1)
							begin
								rx_state <= RX_IDLE;
								rx_data_register <= nine_rx ? rx_shift[9:1] : {1'b0, rx_shift[9:2]};
								framing <= ~rx_sync;
								// A new overrun sets the bit after the clear, so it wins over a clear in the same cycle.
								if (rx_ready_flag)
									overrun <= 1'b1;
								rx_set  <= 1'b1;
							end
						end
					end
				end
				RX_AUTO:
				begin
					// Count clocks until the fifth rising edge of the sync character.
					if (rx_rise)
						ab_edges <= ab_edges + 3'h1;
					if (ab_edges != 3'h0)
					begin
						ab_cnt <= ab_cnt + 16'h0001;
						if (ab_cnt == 16'hffff)
						begin
							ab_ovf <= 1'b1;
							rx_set <= 1'b1;
						end
					end
					if (rx_rise & (ab_edges == `ASU_AB_EDGES - 3'h1))
					begin
						rx_state  <= RX_IDLE;
						ab_done   <= 1'b1;
						ab_result <= {4'h0, ab_cnt[15:4]};
						if (ab_ovf)
							rx_set <= 1'b1;
					end
					else if (~ab_en)
						rx_state <= RX_IDLE;
				end
				RX_WAKE:
				begin
					if (rx_fall)
						rx_set <= 1'b1;
					if (rx_rise & ~rx_sync_low_seen_n)
					begin
						wake_clr <= 1'b1;
						rx_state <= RX_IDLE;
					end
					else if (~wake_en)
						rx_state <= RX_IDLE;
				end
				default:
					rx_state <= RX_IDLE;
			endcase
		end
	end

	// Tracks that the break's falling edge came first in the wake state.
	always @(posedge i_core_clk)
	begin
		if (i_sys_rst | (rx_state != RX_WAKE))
			rx_sync_low_seen_n <= 1'b1;
		else if (rx_fall)
			rx_sync_low_seen_n <= 1'b0;
	end

	// -------------------------------------------------------------------------
	// Register writes, holding register and receive flag
	// -------------------------------------------------------------------------
	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			tx_status_control_reg <= `ASU_RST_BYTE;
			rx_status_control_reg <= `ASU_RST_BYTE;
			baud_control_reg      <= `ASU_RST_BYTE;
			divisor_low           <= `ASU_RST_BYTE;
			baud_divisor_high     <= `ASU_RST_BYTE;
			tx_holding_register   <= 9'h000;
			hold_full             <= 1'b0;
			rx_ready_flag         <= 1'b0;
			peripheral_enable_reg <= 2'h0;
		end
		else
		begin
			if (tx_load)
				hold_full <= 1'b0;
			if (i_wr)
			begin
				case (i_addr)
					`ASU_ADDR_TX_STATUS_CONTROL: tx_status_control_reg <= i_wdata;
					`ASU_ADDR_RX_STATUS_CONTROL: rx_status_control_reg <= i_wdata;
					`ASU_ADDR_BAUD_CONTROL:
						baud_control_reg <= {1'b0, 1'b0, i_wdata[5:0]};
					`ASU_ADDR_DIVISOR_LOW:       divisor_low <= i_wdata;
					`ASU_ADDR_DIVISOR_HIGH:      baud_divisor_high <= i_wdata;
					`ASU_ADDR_TX_HOLDING:
					begin
						tx_holding_register <= {tx_status_control_reg[`ASU_TXC_NINTH_DATA], i_wdata};
						hold_full <= 1'b1;
					end
					`ASU_ADDR_PERIPH_ENABLE:     peripheral_enable_reg <= i_wdata[5:4];
					default: ;
				endcase
			end
			// Auto-baud result lands in the divisor; wake clear beats a write.
			if (ab_done)
			begin
				divisor_low       <= ab_result[7:0];
				baud_divisor_high <= ab_result[15:8];
				baud_control_reg[`ASU_BC_AUTOBAUD_EN] <= 1'b0;
			end
			if (wake_clr)
				baud_control_reg[`ASU_BC_WAKE_EN] <= 1'b0;
			// Set wins over the read clear.
			if (rx_set)
				rx_ready_flag <= 1'b1;
			else if (rx_read)
				rx_ready_flag <= 1'b0;
		end
	end
	assign o_rx_irq_req = rx_ready_flag & peripheral_enable_reg[1];

	// -------------------------------------------------------------------------
	// Read data, one cycle after the strobe
	// -------------------------------------------------------------------------
	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
			o_rdata <= 8'h00;
		else if (i_rd)
		begin
			case (i_addr)
				`ASU_ADDR_TX_STATUS_CONTROL:
					o_rdata <= {tx_status_control_reg[7:2], ~tx_busy, tx_status_control_reg[0]};
				`ASU_ADDR_RX_STATUS_CONTROL:
					o_rdata <= {rx_status_control_reg[7:3], framing, overrun, rx_data_register[8]};
				`ASU_ADDR_BAUD_CONTROL:
					o_rdata <= {ab_ovf, (rx_state == RX_IDLE), baud_control_reg[5:0]};
				`ASU_ADDR_DIVISOR_LOW:   o_rdata <= divisor_low;
				`ASU_ADDR_DIVISOR_HIGH:  o_rdata <= baud_divisor_high;
				`ASU_ADDR_TX_HOLDING:    o_rdata <= tx_holding_register[7:0];
				`ASU_ADDR_RX_DATA:       o_rdata <= rx_data_register[7:0];
				`ASU_ADDR_PERIPH_FLAG:
					o_rdata <= {2'h0, rx_ready_flag, tx_empty_flag, 4'h0};
				`ASU_ADDR_PERIPH_ENABLE: o_rdata <= {2'h0, peripheral_enable_reg, 4'h0};
				default:                 o_rdata <= 8'h00;
			endcase
		end
	end

endmodule // asu_serial

// ### test/asu_serial_sva.sv
// Port-level checker for the serial block.
`timescale 1ns/1ps

module asu_serial_sva
(
	input wire logic       i_core_clk,
	input wire logic       i_sys_rst,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic       i_wr,
	input wire logic       i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic       i_receive_pin,
	input wire logic       o_transmit_pin,
	input wire logic       o_transmit_pin_oe,
	input wire logic       o_tx_irq_req,
	input wire logic       o_rx_irq_req
);
	logic pol_m;
	logic ten_m;

	// ----------------
	// Checks
	// ----------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	// A read of the flag register.
	sequence rd_flags_s;
		i_rd && i_addr == 4'h7;
	endsequence

	// A write that masks both interrupt requests.
	sequence mask_all_s;
		i_wr && i_addr == 4'h8 && i_wdata == 8'h00;
	endsequence

	// Mirrors of the polarity and transmit enable bits, which only software changes.
	always @(posedge i_core_clk)
	begin
		if (i_sys_rst)
		begin
			pol_m <= 1'b0;
			ten_m <= 1'b0;
		end
		else if (i_wr && i_addr == 4'h2)
			pol_m <= i_wdata[4];
		else if (i_wr && i_addr == 4'h0)
			ten_m <= i_wdata[5];
	end

	oe_follows_a: assert property (
		i_wr && i_addr == 4'h1 |=> o_transmit_pin_oe == $past(i_wdata[7]))
		else $error("pin enable does not follow port enable");
	unmapped_read_a: assert property (
		i_rd && i_addr > 4'h8 |=> o_rdata == 8'h00)
		else $error("unmapped index reads non-zero");
	rdata_hold_a: assert property (
		!i_rd |=> $stable(o_rdata))
		else $error("read data moved without a read");
	bit_time_a: assert property (
		$changed(o_transmit_pin) |=> $stable(o_transmit_pin)[*8])
		else $error("transmit level shorter than a bit");
	tx_flag_read_a: assert property (
		rd_flags_s ##0 o_tx_irq_req |=> o_rdata[4])
		else $error("tx request without empty flag");
	rx_flag_read_a: assert property (
		rd_flags_s ##0 o_rx_irq_req |=> o_rdata[5])
		else $error("rx request without ready flag");
	flag_spare_a: assert property (
		rd_flags_s |=> o_rdata[7:6] == 2'b00 && o_rdata[3:0] == 4'h0)
		else $error("spare flag bits set");
	mask_irq_a: assert property (
		mask_all_s |=> !o_tx_irq_req && !o_rx_irq_req)
		else $error("request stays up after masking");
	idle_level_a: assert property (
		!ten_m && $stable(pol_m) |-> o_transmit_pin == !pol_m)
		else $error("idle level wrong for polarity");
endmodule // asu_serial_sva

// ### test/asu_remote.sv
// Remote serial node: drives the receive line and decodes the transmit line.
`timescale 1ns/1ps

module asu_remote
#(
	parameter int BIT_CLKS = 16
)
(
	input  wire logic i_clk,
	input  wire logic i_line,
	output logic      o_line
);
	logic [8:0] rx_q[$];
	int         st_q[$];
	int         cyc = 0;
	int         k;
	logic [7:0] shreg;

	// ----------------
	// Sender
	// ----------------
	initial o_line = 1'b1; // Idle at mark.

	// Hold the line at one level for n bit times, changed at a clock edge.
	task automatic hold(input logic v, input int n);
		@(posedge i_clk);
		o_line <= v;
		repeat (n * BIT_CLKS - 1) @(posedge i_clk);
	endtask

	// Wake character: all zeros, ten bit times low.
	task automatic send_break();
		hold(1'b0, 10);
	endtask

	// ----------------
	// Receiver
	// ----------------
	// Cycle count that time-stamps each start bit.
	always @(posedge i_clk) cyc <= cyc + 1;

	// Decode one frame per falling edge, sampling in the middle of each bit.
	always
	begin
		@(negedge i_line);
		st_q.push_back(cyc);
		repeat (BIT_CLKS / 2) @(posedge i_clk);
		for (k = 0; k < 8; k++)
		begin
			repeat (BIT_CLKS) @(posedge i_clk);
			shreg[k] = i_line;
		end
		repeat (BIT_CLKS) @(posedge i_clk);
		rx_q.push_back({i_line, shreg}); // Stop bit on top.
	end
endmodule // asu_remote

// ### test/tb_top.sv
// Self-checking testbench for the serial block.
`timescale 1ns/1ps
`include "asu_regs.vh"

module tb_top;
	logic       i_core_clk;
	logic       i_sys_rst;
	logic [3:0] i_addr;
	logic [7:0] i_wdata;
	logic       i_wr;
	logic       i_rd;
	wire  [7:0] o_rdata;
	wire        rx_line;
	wire        o_transmit_pin;
	wire        o_transmit_pin_oe;
	wire        o_tx_irq_req;
	wire        o_rx_irq_req;
	int         err_total = 0;
	int         n_tests = 0;
	int         cyc = 0;
	int         d;
	logic [7:0] rv;
	logic [3:0] rst_a [4] = '{4'h1, 4'h7, 4'h8, 4'hf};

	asu_serial DUT
	(
		.i_core_clk       (i_core_clk),
		.i_sys_rst        (i_sys_rst),
		.i_addr           (i_addr),
		.i_wdata          (i_wdata),
		.i_wr             (i_wr),
		.i_rd             (i_rd),
		.o_rdata          (o_rdata),
		.i_receive_pin    (rx_line),
		.o_transmit_pin   (o_transmit_pin),
		.o_transmit_pin_oe(o_transmit_pin_oe),
		.o_tx_irq_req     (o_tx_irq_req),
		.o_rx_irq_req     (o_rx_irq_req)
	);

	asu_remote #(.BIT_CLKS(16)) u_remote
	(
		.i_clk (i_core_clk),
		.i_line(o_transmit_pin),
		.o_line(rx_line)
	);

	// ----------------
	// Helpers
	// ----------------
	// 100 MHz clock.
	initial
	begin
		i_core_clk = 1'b0;
		forever #5 i_core_clk = ~i_core_clk;
	end

	// Compare one value and count it.
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle register write.
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		#1;
	endtask

	// One-cycle register read; data stand in the following cycle.
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1 v = o_rdata;
	endtask

	// Read and compare the masked bits.
	task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e,
		input string nm);
		rd(a, rv);
		chk(nm, rv & m, e);
	endtask

	// Print the counts and the verdict, then stop.
	task automatic summarize();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ----------------
	// Scenarios
	// ----------------
	// Reset state, with a write to an unmapped index that must vanish.
	task automatic t_reset();
		wr(4'hf, 8'hff);
		foreach (rst_a[i]) rc(rst_a[i], 8'hff, 8'h00, "reset_val");
		chk("idle_pin", o_transmit_pin, 1'b1);
		chk("oe_off", o_transmit_pin_oe, 1'b0);
	endtask

	// Enable order, queued back-to-back characters, flag timing and masking.
	task automatic t_tx();
		wr(`ASU_ADDR_RX_STATUS_CONTROL, 8'h80);
		chk("oe_on", o_transmit_pin_oe, 1'b1);
		wr(`ASU_ADDR_TX_HOLDING, 8'hff);
		repeat (40) @(posedge i_core_clk);
		chk("no_send", u_remote.st_q.size(), 0);
		wr(`ASU_ADDR_PERIPH_ENABLE, 8'h10);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h10, 8'h00, "txe_off");
		// The byte held while disabled goes out as soon as transmit is enabled.
		wr(`ASU_ADDR_TX_STATUS_CONTROL, 8'h20);
		@(posedge i_core_clk);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h10, 8'h10, "txe_on");
		chk("tx_irq", o_tx_irq_req, 1'b1);
		for (d = 0; d < 400 && u_remote.rx_q.size() < 1; d++) @(posedge i_core_clk);
		repeat (16) @(posedge i_core_clk);
		wr(`ASU_ADDR_TX_HOLDING, 8'ha5);
		wr(`ASU_ADDR_TX_HOLDING, 8'h3c);
		repeat (2 * `ASU_TCY_CLOCKS) @(posedge i_core_clk);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h10, 8'h00, "txe_full");
		wr(`ASU_ADDR_PERIPH_ENABLE, 8'h00); // Last character queued: mask.
		chk("tx_irq_mask", o_tx_irq_req, 1'b0);
		for (d = 0; d < 450 && u_remote.rx_q.size() < 3; d++) @(posedge i_core_clk);
		chk("frames", u_remote.rx_q.size(), 3);
		chk("byte_held", u_remote.rx_q[0], 9'h1ff);
		chk("byte0", u_remote.rx_q[1], 9'h1a5);
		chk("byte1", u_remote.rx_q[2], 9'h13c);
		d = u_remote.st_q[2] - u_remote.st_q[1];
		chk("gap", d >= 160 && d <= 160 + 2 * `ASU_TCY_CLOCKS, 1'b1);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h10, 8'h10, "txe_free");
	endtask

	// Wake on break with reception enabled.
	task automatic t_wake();
		// A one-bit-time low in synchronous mode must not raise the receive flag.
		wr(`ASU_ADDR_TX_STATUS_CONTROL, 8'h30);
		wr(`ASU_ADDR_BAUD_CONTROL, 8'h02);
		u_remote.hold(1'b0, 1);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h20, 8'h00, "wake_sync");
		u_remote.hold(1'b1, 1);
		wr(`ASU_ADDR_TX_STATUS_CONTROL, 8'h20);
		wr(`ASU_ADDR_RX_STATUS_CONTROL, 8'h90);
		wr(`ASU_ADDR_PERIPH_ENABLE, 8'h20);
		wr(`ASU_ADDR_BAUD_CONTROL, 8'h02);
		u_remote.send_break();
		rc(`ASU_ADDR_BAUD_CONTROL, 8'h02, 8'h02, "wake_held");
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h20, 8'h20, "wake_flag");
		chk("rx_irq", o_rx_irq_req, 1'b1);
		u_remote.hold(1'b1, 2);
		rc(`ASU_ADDR_BAUD_CONTROL, 8'h02, 8'h00, "wake_done");
		rd(`ASU_ADDR_RX_DATA, rv);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h20, 8'h00, "wake_clr");
		rc(`ASU_ADDR_RX_STATUS_CONTROL, 8'h06, 8'h00, "no_rx");
	endtask

	// Auto-baud with a counter overflow before the fifth rising edge.
	task automatic t_abd();
		wr(`ASU_ADDR_BAUD_CONTROL, 8'h01);
		u_remote.hold(1'b0, 1);
		u_remote.hold(1'b1, 1);
		u_remote.hold(1'b0, 4200);
		rc(`ASU_ADDR_BAUD_CONTROL, 8'hc0, 8'h80, "abd_ovf");
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h20, 8'h20, "abd_flag");
		rd(`ASU_ADDR_RX_DATA, rv);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h20, 8'h00, "abd_read");
		for (int i = 0; i < 6; i++) u_remote.hold(~i[0], 1);
		rc(`ASU_ADDR_BAUD_CONTROL, 8'h40, 8'h00, "abd_busy");
		u_remote.hold(1'b1, 1);
		rc(`ASU_ADDR_PERIPH_FLAG, 8'h20, 8'h20, "abd_again");
		rc(`ASU_ADDR_BAUD_CONTROL, 8'hc1, 8'hc0, "abd_end");
		rd(`ASU_ADDR_RX_DATA, rv);
		wr(`ASU_ADDR_BAUD_CONTROL, 8'h00);
		rc(`ASU_ADDR_BAUD_CONTROL, 8'h80, 8'h00, "ovf_clr");
	endtask

	// Idle level follows the polarity bit.
	task automatic t_pol();
		wr(`ASU_ADDR_TX_STATUS_CONTROL, 8'h00);
		wr(`ASU_ADDR_BAUD_CONTROL, 8'h10);
		repeat (10) @(posedge i_core_clk);
		chk("pol_inv", o_transmit_pin, 1'b0);
		wr(`ASU_ADDR_BAUD_CONTROL, 8'h00);
		repeat (10) @(posedge i_core_clk);
		chk("pol_norm", o_transmit_pin, 1'b1);
	endtask

	// ----------------
	// Main sequence
	// ----------------
	// Reset for five cycles, then run every scenario.
	initial
	begin
		i_sys_rst = 1'b1;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		repeat (5) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
		t_reset();
		t_tx();
		t_wake();
		t_abd();
		t_pol();
		summarize();
	end

	// Hang guard: the run needs about 68000 cycles.
	always @(posedge i_core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 90000)
		begin
			err_total++;
			summarize();
		end
	end
endmodule // tb_top

bind asu_serial asu_serial_sva u_sva
(
	.i_core_clk       (i_core_clk),
	.i_sys_rst        (i_sys_rst),
	.i_addr           (i_addr),
	.i_wdata          (i_wdata),
	.i_wr             (i_wr),
	.i_rd             (i_rd),
	.o_rdata          (o_rdata),
	.i_receive_pin    (i_receive_pin),
	.o_transmit_pin   (o_transmit_pin),
	.o_transmit_pin_oe(o_transmit_pin_oe),
	.o_tx_irq_req     (o_tx_irq_req),
	.o_rx_irq_req     (o_rx_irq_req)
);
